//--- rtl/ctu_wdt_map.vh
`ifndef CTU_WDT_MAP_VH
`define CTU_WDT_MAP_VH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define ADDR_GLOBAL_CMD 8'h00
`define ADDR_DELAY_CYCLE 8'h04
`define ADDR_SW_LOAD 8'h08
`define ADDR_CMD2 8'h0c
`define ADDR_IMAGE 8'h10
`define ADDR_COUNT 8'h20
`define ADDR_PORTE_SFO 8'h30
`define ADDR_POWER_MODE 8'h34
`define ADDR_STATUS 8'h38
// ----------------------------------------
// Fields
// ----------------------------------------
`define GCMD_SCALE 0
`define GCMD_START 1
`define GCMD_MODE 2
`define GCMD_WDOG 3
`define CMD_DIR 1
`define SWLOAD_WDOG 2
`define PMR_TMR_CLK 7
// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define GCMD_RST 4'h0
`define DELAY_RST 5'h00
`define DIV_BASE 9'h004
`define SCALE_MUL 9'h008
`define TC_HOLD 3'h4
`endif

//--- rtl/ctu_watchdog_tc_clock_divisor.v
// Behaviour
// - Unit two watchdog in either global mode
// - Event mode: unit two only watchdog
// - Watchdog decrements per tick, terminal times out
// - Software load bit two reloads unit two
// - Image two frozen once watchdog on
// - Active-high timeout pulse, four clocks wide
// - Timeout pulse feeds logic array
// - Watchdog locks unit two until reset
// - Watchdog ignores timer clock enable bit
// - Terminal counts out on port E and feedback
// - Cascade counts on terminal falling edge
// - Port E pin gated by its enable bit
// - Terminal count high four input clocks minimum
// - One shared prescaler, ratio 4 to 280
// - Delay value 0 to 31 from register
// - Scale bit is global command bit zero
// - Reset gives ratio four
// - Wrap up is overflow, wrap down underflow
//
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ctu_wdt_map.vh"
module ctu_watchdog_tc_clock_divisor (
  input wire clock,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire power_down,
  output reg [3:0] terminal_count_strobes,
  output reg [3:0] port_e_pins,
  output reg watchdog_pulse
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [3:0] gcmd_ff;
  reg [4:0] delay_ff;
  reg [3:0] dir_ff;
  reg [3:0] porte_en_ff;
  reg pmr_clk_ff;
  reg [15:0] image_ff [0:3];
  reg [15:0] count_ff [0:3];
  reg [3:0] tc_ff;
  reg [2:0] tc_hold_ff [0:3];
  reg [3:0] tc_prev_ff;
  reg [8:0] pre_cnt_ff;
  reg tick_ff;
  reg wr_pend_ff;
  reg [7:0] wr_addr_ff;
  reg [3:0] sw_load_ff;
  wire [7:0] a = haddr[7:0];
  wire take = hsel & hready & htrans[1];
  wire wdog = gcmd_ff[`GCMD_WDOG];
  wire start = gcmd_ff[`GCMD_START];
  wire [3:0] sw_load_w;
  wire [3:0] reg_wr_img;
  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  wire [8:0] base_div = `DIV_BASE + {4'h0, delay_ff};
  wire [8:0] ratio = gcmd_ff[`GCMD_SCALE] ? base_div * `SCALE_MUL : base_div;
  // Timers run if the timer clock is on or power is up; the watchdog runs regardless
  wire run_all = start & (pmr_clk_ff | ~power_down);
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt_ff <= 9'h000;
      tick_ff <= 1'b0;
    end else if (pre_cnt_ff >= ratio - 9'h001) begin
      pre_cnt_ff <= 9'h000;
      tick_ff <= 1'b1;
    end else begin
      pre_cnt_ff <= pre_cnt_ff + 9'h001;
      tick_ff <= 1'b0;
    end
  end
  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  function [2:0] unit_of;
    input [7:0] ad;
    input [7:0] base;
    begin
      unit_of = (ad[7:4] == base[7:4]) ? {1'b1, ad[3:2]} : 3'b000;
    end
  endfunction
  wire [2:0] img_sel = unit_of(wr_addr_ff, `ADDR_IMAGE);
  wire [2:0] cnt_rd = unit_of(a, `ADDR_COUNT);
  wire [2:0] img_rd = unit_of(a, `ADDR_IMAGE);
  // Global command and unit two are locked once watchdog is set
  wire gcmd_wr = wr_pend_ff & (wr_addr_ff == `ADDR_GLOBAL_CMD) & ~wdog;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
      gcmd_ff <= `GCMD_RST;
      delay_ff <= `DELAY_RST;
      dir_ff <= 4'h0;
      porte_en_ff <= 4'h0;
      pmr_clk_ff <= 1'b0;
      sw_load_ff <= 4'h0;
    end else begin
      wr_pend_ff <= take & hwrite;
      if (take)
        wr_addr_ff <= a;
      hrdata <= 32'h00000000;
      if (take & ~hwrite) begin
        if (a == `ADDR_GLOBAL_CMD)
          hrdata <= {28'h0000000, gcmd_ff};
        else if (a == `ADDR_DELAY_CYCLE)
          hrdata <= {27'h0000000, delay_ff};
        else if (a == `ADDR_CMD2)
          hrdata <= {28'h0000000, dir_ff};
        else if (a == `ADDR_PORTE_SFO)
          hrdata <= {28'h0000000, porte_en_ff};
        else if (a == `ADDR_POWER_MODE)
          hrdata <= {24'h000000, pmr_clk_ff, 7'h00};
        else if (a == `ADDR_STATUS)
          hrdata <= {27'h0000000, wdog, tc_ff};
        else if (cnt_rd[2])
          hrdata <= {16'h0000, count_ff[cnt_rd[1:0]]};
        else if (img_rd[2])
          hrdata <= {16'h0000, image_ff[img_rd[1:0]]};
      end
      sw_load_ff <= 4'h0;
      if (gcmd_wr)
        gcmd_ff <= hwdata[3:0];
      if (wr_pend_ff) begin
        if (wr_addr_ff == `ADDR_DELAY_CYCLE & ~wdog)
          delay_ff <= hwdata[4:0];
        if (wr_addr_ff == `ADDR_CMD2)
          dir_ff <= wdog ? {hwdata[3], 1'b0, hwdata[1:0]} : hwdata[3:0];
        if (wr_addr_ff == `ADDR_PORTE_SFO)
          porte_en_ff <= hwdata[3:0];
        if (wr_addr_ff == `ADDR_POWER_MODE)
          pmr_clk_ff <= hwdata[`PMR_TMR_CLK];
        if (wr_addr_ff == `ADDR_SW_LOAD)
          sw_load_ff <= hwdata[3:0];
      end
    end
  end
  // ----------------------------------------
  // Counter units
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : unit
      // Unit two under watchdog ignores image writes and counts down
      wire is_wd = (g == 2) & wdog;
      wire down = is_wd | ~dir_ff[g];
      wire [15:0] cur = count_ff[g];
      wire img_w = wr_pend_ff & img_sel[2] & (img_sel[1:0] == g) & ~is_wd;
      // Odd units cascade from the previous unit's terminal falling edge
      wire casc = (g % 2 == 1) & dir_ff[3] & tc_prev_ff[g - (g % 2)] & ~tc_ff[g - (g % 2)];
      wire chained = dir_ff[3] & (g % 2 == 1);
      wire plain_en = run_all & (chained ? casc : tick_ff);
      wire en = is_wd ? (start & tick_ff) : plain_en;
      wire wrap = en & (down ? (cur == 16'h0000) : (cur == 16'hffff));
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          image_ff[g] <= 16'h0000;
          count_ff[g] <= 16'h0000;
          tc_ff[g] <= 1'b0;
          tc_hold_ff[g] <= 3'h0;
          tc_prev_ff[g] <= 1'b0;
        end else begin
          tc_prev_ff[g] <= tc_ff[g];
          if (img_w)
            image_ff[g] <= hwdata[15:0];
          if (sw_load_ff[g])
            count_ff[g] <= image_ff[g];
          else if (wrap)
            count_ff[g] <= image_ff[g];
          else if (en)
            count_ff[g] <= down ? cur - 16'h0001 : cur + 16'h0001;
          // Hold in external clock periods, at least four
          if (wrap) begin
            tc_ff[g] <= 1'b1;
            tc_hold_ff[g] <= `TC_HOLD - 3'h1;
          end else if (tc_hold_ff[g] != 3'h0)
            tc_hold_ff[g] <= tc_hold_ff[g] - 3'h1;
          else
            tc_ff[g] <= 1'b0;
        end
      end
    end
  endgenerate
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      terminal_count_strobes <= 4'h0;
      port_e_pins <= 4'h0;
      watchdog_pulse <= 1'b0;
    end else begin
      terminal_count_strobes <= tc_ff;
      port_e_pins <= tc_ff & porte_en_ff;
      watchdog_pulse <= tc_ff[2] & wdog;
    end
  end
endmodule

//--- tb/ctu_props.sv
`timescale 1ns/1ps
module ctu_props (
  input wire clock,
  input wire rst_n,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire [3:0] terminal_count_strobes,
  input wire [3:0] port_e_pins,
  input wire watchdog_pulse
);
  reg hole_ff;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) hole_ff <= 1'b0;
    else hole_ff <= hsel && hready && htrans[1] && !hwrite && haddr[7:0] > 8'h38;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_bus_ready_okay: assert property (hreadyout && !hresp) else $error("bus stall or error");
  a_hole_reads_zero: assert property (hole_ff |-> hrdata == 32'h0) else $error("hole read");
  a_pin_gated:
    assert property ((port_e_pins & ~terminal_count_strobes) == 4'h0) else $error("pin leak");
  a_tc_min_width:
    assert property ($rose(terminal_count_strobes[0]) |-> terminal_count_strobes[0] [*4])
    else $error("tc0 short");
  a_tc2_min_width:
    assert property ($rose(terminal_count_strobes[2]) |-> terminal_count_strobes[2] [*4])
    else $error("tc2 short");
  a_wd_from_tc:
    assert property (watchdog_pulse |-> terminal_count_strobes[2]) else $error("stray pulse");
  a_wd_pulse_width:
    assert property ($rose(watchdog_pulse) |-> watchdog_pulse [*4]) else $error("pulse short");
  a_quiet_after_reset:
    assert property ($rose(rst_n) |-> !watchdog_pulse && terminal_count_strobes == 4'h0)
    else $error("busy after reset");
endmodule
bind ctu_watchdog_tc_clock_divisor ctu_props i_ctu_props (.clock(clock), .rst_n(rst_n),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port_e_pins(port_e_pins),
  .terminal_count_strobes(terminal_count_strobes), .watchdog_pulse(watchdog_pulse));

//--- tb/logic_array_model.sv
`timescale 1ns/1ps
// ----
// Logic array consuming the timer outputs
// ----
module logic_array_model (
  input wire clock,
  input wire rst_n,
  input wire [3:0] terminal_count_strobes,
  input wire watchdog_pulse,
  output reg [15:0] wd_count,
  output wire wd_pin_n
);
  reg tc0_ff;
  reg wd_ff;
  assign wd_pin_n = ~watchdog_pulse;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      tc0_ff <= 1'b0;
      wd_ff <= 1'b0;
      wd_count <= 16'h0;
    end else begin
      tc0_ff <= terminal_count_strobes[0];
      wd_ff <= watchdog_pulse;
      if (!wd_ff && watchdog_pulse) wd_count <= wd_count + 16'h1;
    end
  end
endmodule

//--- tb/tb_ctu_watchdog_tc_clock_divisor.sv
`timescale 1ns/1ps
module tb_ctu_watchdog_tc_clock_divisor;
  reg clock = 0, rst_n = 0, hsel = 0, hwrite = 0, power_down = 0;
  reg [31:0] haddr = 0, hwdata = 0, rd;
  reg [1:0] htrans = 0;
  reg [15:0] c0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, watchdog_pulse;
  wire [3:0] terminal_count_strobes, port_e_pins;
  wire [15:0] wd_count;
  wire [4:0] mon = {watchdog_pulse, terminal_count_strobes};
  int n, mismatches = 0, tests_run = 0;
  always #20 clock = ~clock;
  ctu_watchdog_tc_clock_divisor i_ctu_watchdog_tc_clock_divisor (.clock(clock), .rst_n(rst_n),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .power_down(power_down), .terminal_count_strobes(terminal_count_strobes),
    .port_e_pins(port_e_pins), .watchdog_pulse(watchdog_pulse));
  logic_array_model i_logic_array_model (.clock(clock), .rst_n(rst_n), .wd_pin_n(),
    .terminal_count_strobes(terminal_count_strobes), .watchdog_pulse(watchdog_pulse),
    .wd_count(wd_count));
  // ----
  // Bus cycles and checks
  // ----
  task chk(input [31:0] seen, input [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task xfer(input w, input [7:0] a, input [31:0] d);
    @(posedge clock);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask
  // Cycles between two rising edges of one monitored output
  task per(input int b);
    n = 0;
    while (mon[b] !== 1'b0) @(posedge clock);
    while (mon[b] !== 1'b1) @(posedge clock);
    while (mon[b] === 1'b1) begin
      @(posedge clock);
      n++;
    end
    while (mon[b] !== 1'b1) begin
      @(posedge clock);
      n++;
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #200000;
    mismatches++;
    results;
  end
  initial begin
    repeat (8) @(posedge clock);
    rst_n <= 1;
    xfer(0, 8'h00, 0); chk(rd, 0);
    xfer(0, 8'h04, 0); chk(rd, 0);
    xfer(0, 8'h40, 0); chk(rd, 0);
    xfer(1, 8'h04, 1); xfer(1, 8'h10, 1); xfer(1, 8'h30, 1); xfer(1, 8'h00, 2);
    per(0); chk(n, 10);
    chk(port_e_pins, 4'h1);
    xfer(1, 8'h00, 0); xfer(1, 8'h04, 31); xfer(1, 8'h10, 0); xfer(1, 8'h00, 3);
    per(0); chk(n, 280);
    xfer(1, 8'h00, 0); xfer(1, 8'h04, 0); xfer(1, 8'h18, 3);
    xfer(1, 8'h00, 32'ha);
    // A wrap left over from before the lock may still reach the model
    repeat (3) xfer(1, 8'h08, 4);
    c0 = wd_count;
    repeat (10) xfer(1, 8'h08, 4);
    chk({16'h0, wd_count}, {16'h0, c0});
    power_down <= 1;
    xfer(1, 8'h18, 100); xfer(1, 8'h00, 0); xfer(1, 8'h04, 5);
    per(4); chk(n, 16);
    xfer(0, 8'h00, 0); chk(rd, 32'ha);
    xfer(0, 8'h38, 0); chk(rd[4], 1'b1);
    results;
  end
endmodule
